// ===== fst_pkg.sv
// Constants for the FIFO status and transmit length block.
// Assumes a single 125 MHz system clock and an 8-bit register port.
package fst_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [4:0] FST_OFS_FIFO_LEVEL_STATUS = 5'h1c;
  localparam logic [4:0] FST_OFS_TX_LENGTH_HIGH = 5'h1d;
  localparam logic [4:0] FST_OFS_TX_LENGTH_LOW_PARTIAL = 5'h1e;

  // ----------------------------------------------------------------
  // Field layout
  // ----------------------------------------------------------------
  localparam int FST_OVERFLOW_BIT = 7;
  localparam int FST_PARTIAL_FLAG_BIT = 0;
  localparam int FST_FIFO_DEPTH = 127;
  localparam logic [6:0] FST_FIFO_FULL = 7'h7f;
  localparam logic [7:0] FST_TXLEN_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Transmit sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    FST_TX_IDLE = 3'b001,
    FST_TX_SEND = 3'b010,
    FST_TX_EOF = 3'b100
  } fst_tx_state_t;

endpackage : fst_pkg

// ===== fst_fifo_mem.sv
// 127-byte data store with fill count and overflow flag.
// Assumes push and pop come from logic on clk_sys.
module fst_fifo_mem
  import fst_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Write side
  input wire logic push,
  input wire logic [7:0] push_data,
  // Read side
  input wire logic pop,
  output logic [7:0] pop_data,
  // Control and state
  input wire logic flush,
  input wire logic clr_overflow,
  output logic [6:0] fifo_level_count,
  output logic overflow
);

  logic [7:0] mem [0:FST_FIFO_DEPTH-1];
  logic [6:0] wr_q, wr_d, rd_q, rd_d, cnt_q, cnt_d;
  logic ovf_q, ovf_d;
  logic do_push, do_pop;

  function automatic logic [6:0] fst_wrap(input logic [6:0] p);
    fst_wrap = (p == FST_FIFO_FULL - 7'h01) ? 7'h00 : p + 7'h01;
  endfunction : fst_wrap

  always_comb
  begin
    do_pop = pop && (cnt_q != 7'h00);
    do_push = push && ((cnt_q != FST_FIFO_FULL) || do_pop);
    wr_d = do_push ? fst_wrap(wr_q) : wr_q;
    rd_d = do_pop ? fst_wrap(rd_q) : rd_q;
    cnt_d = cnt_q + {6'h00, do_push} - {6'h00, do_pop};
    ovf_d = ovf_q;
    if (clr_overflow)
      ovf_d = 1'b0;
    if (push && !do_push)
      ovf_d = 1'b1;
    if (flush)
    begin
      wr_d = 7'h00;
      rd_d = 7'h00;
      cnt_d = 7'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      wr_q <= 7'h00;
      rd_q <= 7'h00;
      cnt_q <= 7'h00;
      ovf_q <= 1'b0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ovf_q <= ovf_d;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (do_push)
      mem[wr_q] <= push_data;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
      pop_data <= 8'h00;
    else if (do_pop)
      pop_data <= mem[rd_q];
  end

  assign fifo_level_count = cnt_q;
  assign overflow = ovf_q;

  property p_count_up;
    @(posedge clk_sys) disable iff (!rstn)
    (do_push && !do_pop && !flush) |=> cnt_q == $past(cnt_q) + 7'h01;
  endproperty
  a_count_up: assert property (p_count_up) else $error("fill count did not rise on push");

  property p_full_ovf;
    @(posedge clk_sys) disable iff (!rstn)
    (push && cnt_q == FST_FIFO_FULL && !pop) |=> ovf_q;
  endproperty
  a_full_ovf: assert property (p_full_ovf) else $error("overflow not set on push into full store");

endmodule : fst_fifo_mem

// ===== fst_top.sv
// FIFO status, fill count and transmit length registers of the reader.
// Assumes register accesses come from the host port logic on clk_sys;
// chip enable arrives from a pin and is synchronised here.
//
// How it works
// - overflow bit set beyond 127 bytes
// - low seven bits report FIFO fill
// - high length register holds count bits 11..4
// - length registers clear when disabled or at EOF
// - low register bits 7..4 hold count 3..0
// - bits 3..1 give partial byte bits
// - bit 0 marks last byte partial
module fst_top
  import fst_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Chip enable pin
  input wire logic chip_en,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [4:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Host FIFO data port
  input wire logic fifo_wr,
  input wire logic [7:0] fifo_wdata,
  input wire logic fifo_rd,
  output logic [7:0] fifo_rdata,
  // Transmit start and encoder side
  input wire logic tx_start,
  input wire logic enc_ready,
  output logic enc_valid,
  output logic [7:0] enc_data,
  output logic [2:0] enc_bits_last,
  output logic enc_last_partial,
  output logic enc_last,
  output logic tx_eof
);

  // ----------------------------------------------------------------
  // Enable synchroniser
  // ----------------------------------------------------------------
  logic en_s1_q, en_s2_q;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      en_s1_q <= 1'b0;
      en_s2_q <= 1'b0;
    end
    else
    begin
      en_s1_q <= chip_en;
      en_s2_q <= en_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // Register file
  // ----------------------------------------------------------------
  logic [7:0] txlen_hi_q, txlen_hi_d, txlen_lo_q, txlen_lo_d;
  logic [7:0] rdata_q, rdata_d;
  logic [6:0] fifo_level_count;
  logic overflow, eof_q, eof_d;
  logic [11:0] tx_full_byte_count;
  logic [2:0] partial_byte_bits;
  logic partial_flag;

  function automatic logic fst_hit(input logic [4:0] a, input logic [4:0] ofs);
    fst_hit = (a == ofs);
  endfunction : fst_hit

  assign tx_full_byte_count = {txlen_hi_q, txlen_lo_q[7:4]};
  assign partial_byte_bits = txlen_lo_q[3:1];
  assign partial_flag = txlen_lo_q[FST_PARTIAL_FLAG_BIT];

  always_comb
  begin
    txlen_hi_d = txlen_hi_q;
    txlen_lo_d = txlen_lo_q;
    if (reg_wr && fst_hit(reg_addr, FST_OFS_TX_LENGTH_HIGH))
      txlen_hi_d = reg_wdata;
    if (reg_wr && fst_hit(reg_addr, FST_OFS_TX_LENGTH_LOW_PARTIAL))
      txlen_lo_d = reg_wdata;
    if (!en_s2_q || eof_q)
    begin
      txlen_hi_d = FST_TXLEN_RESET;
      txlen_lo_d = FST_TXLEN_RESET;
    end
    rdata_d = rdata_q;
    if (reg_rd)
    begin
      if (fst_hit(reg_addr, FST_OFS_FIFO_LEVEL_STATUS))
        rdata_d = {overflow, fifo_level_count};
      else if (fst_hit(reg_addr, FST_OFS_TX_LENGTH_HIGH))
        rdata_d = txlen_hi_q;
      else if (fst_hit(reg_addr, FST_OFS_TX_LENGTH_LOW_PARTIAL))
        rdata_d = txlen_lo_q;
      else
        rdata_d = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      txlen_hi_q <= FST_TXLEN_RESET;
      txlen_lo_q <= FST_TXLEN_RESET;
      rdata_q <= 8'h00;
    end
    else
    begin
      txlen_hi_q <= txlen_hi_d;
      txlen_lo_q <= txlen_lo_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;

  // ----------------------------------------------------------------
  // Transmit sequencer
  // ----------------------------------------------------------------
  fst_tx_state_t st_q, st_d;
  logic [11:0] left_q, left_d;
  logic [11:0] total_d, total_q;
  logic seq_pop, pend_q, pend_d, enc_valid_q, enc_valid_d;
  logic [7:0] fifo_q;

  always_comb
  begin
    st_d = st_q;
    left_d = left_q;
    total_d = total_q;
    seq_pop = 1'b0;
    pend_d = 1'b0;
    eof_d = 1'b0;
    case (st_q)
      FST_TX_IDLE:
      begin
        if (tx_start && en_s2_q)
        begin
          total_d = tx_full_byte_count + {11'h000, partial_flag};
          left_d = total_d;
          st_d = (total_d == 12'h000) ? FST_TX_EOF : FST_TX_SEND;
        end
      end
      FST_TX_SEND:
      begin
        if (!enc_valid_q && !pend_q && fifo_level_count != 7'h00)
        begin
          seq_pop = 1'b1;
          pend_d = 1'b1;
        end
        if (enc_valid_q && enc_ready)
        begin
          left_d = left_q - 12'h001;
          if (left_q == 12'h001)
            st_d = FST_TX_EOF;
        end
      end
      FST_TX_EOF:
      begin
        eof_d = 1'b1;
        st_d = FST_TX_IDLE;
      end
      default:
        st_d = FST_TX_IDLE;
    endcase
  end

  always_comb
  begin
    enc_valid_d = enc_valid_q;
    if (pend_q)
      enc_valid_d = 1'b1;
    else if (enc_valid_q && enc_ready)
      enc_valid_d = 1'b0;
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      st_q <= FST_TX_IDLE;
      left_q <= 12'h000;
      total_q <= 12'h000;
      pend_q <= 1'b0;
      eof_q <= 1'b0;
      enc_valid_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      left_q <= left_d;
      total_q <= total_d;
      pend_q <= pend_d;
      eof_q <= eof_d;
      enc_valid_q <= enc_valid_d;
    end
  end

  assign enc_valid = enc_valid_q;
  assign enc_data = fifo_q;
  assign enc_last = enc_valid_q && (left_q == 12'h001);
  // Partial marker only on a partial final byte; width shown on every byte while the flag is set
  assign enc_last_partial = enc_last && partial_flag;
  assign enc_bits_last = partial_flag ? partial_byte_bits : 3'h0;
  assign tx_eof = eof_q;
  assign fifo_rdata = fifo_q;

  // ----------------------------------------------------------------
  // Data store
  // ----------------------------------------------------------------
  fst_fifo_mem u_mem (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .push(fifo_wr),
    .push_data(fifo_wdata),
    .pop(fifo_rd || seq_pop),
    .pop_data(fifo_q),
    .flush(!en_s2_q),
    .clr_overflow(!en_s2_q),
    .fifo_level_count(fifo_level_count),
    .overflow(overflow)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_eof;
    eof_q;
  endsequence

  property p_eof_clears;
    @(posedge clk_sys) disable iff (!rstn)
    s_eof |=> (txlen_hi_q == 8'h00) && (txlen_lo_q == 8'h00);
  endproperty
  a_eof_clears: assert property (p_eof_clears) else $error("length not cleared at EOF");

  property p_disabled_clear;
    @(posedge clk_sys) disable iff (!rstn)
    !en_s2_q |=> txlen_hi_q == 8'h00 && txlen_lo_q == 8'h00;
  endproperty
  a_disabled_clear: assert property (p_disabled_clear) else $error("length not cleared while disabled");

  property p_status_read;
    @(posedge clk_sys) disable iff (!rstn)
    reg_rd && reg_addr == FST_OFS_FIFO_LEVEL_STATUS |=> reg_rdata == {$past(overflow), $past(fifo_level_count)};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  property p_hi_write;
    @(posedge clk_sys) disable iff (!rstn)
    reg_wr && reg_addr == FST_OFS_TX_LENGTH_HIGH && en_s2_q && !eof_q |=> tx_full_byte_count[11:4] == $past(reg_wdata);
  endproperty
  a_hi_write: assert property (p_hi_write) else $error("high length not stored");

  property p_lo_write;
    @(posedge clk_sys) disable iff (!rstn)
    reg_wr && reg_addr == FST_OFS_TX_LENGTH_LOW_PARTIAL && en_s2_q && !eof_q
      |=> tx_full_byte_count[3:0] == $past(reg_wdata[7:4]) && partial_byte_bits == $past(reg_wdata[3:1]);
  endproperty
  a_lo_write: assert property (p_lo_write) else $error("low length not stored");

  property p_full_bits;
    @(posedge clk_sys) disable iff (!rstn)
    !partial_flag |-> enc_bits_last == 3'h0 && !enc_last_partial;
  endproperty
  a_full_bits: assert property (p_full_bits) else $error("partial width used without flag");

  property p_ovf_sticky;
    @(posedge clk_sys) disable iff (!rstn)
    overflow && en_s2_q |=> overflow;
  endproperty
  a_ovf_sticky: assert property (p_ovf_sticky) else $error("overflow dropped");

  property p_fill_down;
    @(posedge clk_sys) disable iff (!rstn)
    fifo_rd && !fifo_wr && !seq_pop && fifo_level_count != 7'h00 && en_s2_q
      |=> fifo_level_count == $past(fifo_level_count) - 7'h01;
  endproperty
  a_fill_down: assert property (p_fill_down) else $error("fill count did not fall");

endmodule : fst_top

// ===== fst_host_model.sv
// Host controller model for the FIFO status and transmit length block.
// Assumes the bench calls its tasks; it drives at falling edges of clk_sys.
module fst_host_model
  import fst_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Register port
  output logic reg_wr,
  output logic reg_rd,
  output logic [4:0] reg_addr,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // FIFO port
  output logic fifo_wr,
  output logic [7:0] fifo_wdata,
  output logic fifo_rd,
  input wire logic [7:0] fifo_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 8'h00;
    fifo_wr = 1'b0;
    fifo_wdata = 8'h00;
    fifo_rd = 1'b0;
  end

  // ----------------------------------------------------------------
  // Bus cycles; released data lines show the inverse of the last value
  // ----------------------------------------------------------------
  task automatic reg_write(input logic [4:0] a, input logic [7:0] v);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_wdata = ~v;
  endtask : reg_write

  task automatic reg_read(input logic [4:0] a, output logic [7:0] v);
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    @(negedge clk_sys);
    v = reg_rdata;
  endtask : reg_read

  task automatic set_length(input logic [11:0] n, input logic [2:0] b, input logic f);
    reg_write(FST_OFS_TX_LENGTH_HIGH, n[11:4]);
    reg_write(FST_OFS_TX_LENGTH_LOW_PARTIAL, {n[3:0], b, f});
  endtask : set_length

  task automatic fifo_push(input logic [7:0] v);
    @(negedge clk_sys);
    fifo_wr = 1'b1;
    fifo_wdata = v;
    @(negedge clk_sys);
    fifo_wr = 1'b0;
    fifo_wdata = ~v;
  endtask : fifo_push

  task automatic fifo_pop(output logic [7:0] v);
    @(negedge clk_sys);
    fifo_rd = 1'b1;
    @(negedge clk_sys);
    fifo_rd = 1'b0;
    v = fifo_rdata;
  endtask : fifo_pop
endmodule : fst_host_model

// ===== test_fst_top.sv
// Self-checking bench for the FIFO status and transmit length block.
// Assumes the host model drives the register and FIFO ports.
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module test_fst_top
  import fst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, rstn, chip_en, tx_start, enc_ready, reg_wr, reg_rd, fifo_wr, fifo_rd;
  logic enc_valid, enc_last_partial, enc_last, tx_eof;
  logic [4:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, fifo_wdata, fifo_rdata, enc_data, d;
  logic [2:0] enc_bits_last;
  int err_count, n_tests, cyc;

  fst_top u_fst_top (.clk_sys, .rstn, .chip_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .fifo_wr, .fifo_wdata, .fifo_rd, .fifo_rdata, .tx_start, .enc_ready, .enc_valid, .enc_data,
    .enc_bits_last, .enc_last_partial, .enc_last, .tx_eof);
  fst_host_model u_fst_host_model (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .fifo_wr, .fifo_wdata, .fifo_rd, .fifo_rdata);

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic check_reset();
    u_fst_host_model.reg_read(FST_OFS_FIFO_LEVEL_STATUS, d);
    `CHK(d, 8'h00)
    u_fst_host_model.reg_read(FST_OFS_TX_LENGTH_HIGH, d);
    `CHK(d, FST_TXLEN_RESET)
    u_fst_host_model.reg_read(FST_OFS_TX_LENGTH_LOW_PARTIAL, d);
    `CHK(d, FST_TXLEN_RESET)
    u_fst_host_model.reg_read(5'h1f, d);
    `CHK(d, 8'h00)
  endtask : check_reset

  task automatic check_fill();
    u_fst_host_model.fifo_push(8'h11);
    u_fst_host_model.fifo_push(8'h22);
    u_fst_host_model.fifo_push(8'h33);
    u_fst_host_model.reg_read(FST_OFS_FIFO_LEVEL_STATUS, d);
    `CHK(d, 8'h03)
    u_fst_host_model.fifo_pop(d);
    `CHK(d, 8'h11)
    u_fst_host_model.reg_read(FST_OFS_FIFO_LEVEL_STATUS, d);
    `CHK(d, 8'h02)
    repeat (3) u_fst_host_model.fifo_pop(d);
    u_fst_host_model.reg_read(FST_OFS_FIFO_LEVEL_STATUS, d);
    `CHK(d, 8'h00)
  endtask : check_fill

  task automatic check_overflow();
    for (int i = 0; i < FST_FIFO_DEPTH; i++) u_fst_host_model.fifo_push(i[7:0]);
    u_fst_host_model.reg_read(FST_OFS_FIFO_LEVEL_STATUS, d);
    `CHK(d, {1'b0, FST_FIFO_FULL})
    u_fst_host_model.fifo_push(8'hee);
    u_fst_host_model.reg_read(FST_OFS_FIFO_LEVEL_STATUS, d);
    `CHK(d, {1'b1, FST_FIFO_FULL})
    u_fst_host_model.fifo_pop(d);
    u_fst_host_model.reg_read(FST_OFS_FIFO_LEVEL_STATUS, d);
    `CHK(d, 8'hfe)
    u_fst_host_model.reg_write(FST_OFS_TX_LENGTH_HIGH, 8'ha5);
    u_fst_host_model.reg_read(FST_OFS_TX_LENGTH_HIGH, d);
    `CHK(d, 8'ha5)
    u_fst_host_model.reg_write(FST_OFS_TX_LENGTH_LOW_PARTIAL, 8'h5a);
    u_fst_host_model.reg_read(FST_OFS_TX_LENGTH_LOW_PARTIAL, d);
    `CHK(d, 8'h5a)
    chip_en = 1'b0;
    repeat (4) @(negedge clk_sys);
    chip_en = 1'b1;
    repeat (4) @(negedge clk_sys);
    u_fst_host_model.reg_read(FST_OFS_FIFO_LEVEL_STATUS, d);
    `CHK(d, 8'h00)
    u_fst_host_model.reg_read(FST_OFS_TX_LENGTH_HIGH, d);
    `CHK(d, FST_TXLEN_RESET)
    u_fst_host_model.reg_read(FST_OFS_TX_LENGTH_LOW_PARTIAL, d);
    `CHK(d, FST_TXLEN_RESET)
  endtask : check_overflow

  task automatic tx_run(input logic [11:0] n, input logic [2:0] b, input logic f);
    int total;
    total = n + f;
    u_fst_host_model.set_length(n, b, f);
    for (int i = 0; i < total; i++) u_fst_host_model.fifo_push(8'h40 + i[7:0]);
    u_fst_host_model.reg_read(FST_OFS_FIFO_LEVEL_STATUS, d);
    `CHK(d, total[7:0])
    @(negedge clk_sys);
    tx_start = 1'b1;
    @(negedge clk_sys);
    tx_start = 1'b0;
    for (int i = 0; i < total; i++)
    begin
      for (int k = 0; k < 20 && enc_valid !== 1'b1; k++) @(negedge clk_sys);
      // Encoder stalls before accepting each byte
      repeat (2) @(negedge clk_sys);
      `CHK(enc_valid, 1'b1)
      `CHK(enc_data, 8'h40 + i[7:0])
      `CHK(enc_last, (i == total - 1))
      if (i == total - 1)
      begin
        `CHK(enc_last_partial, f)
        `CHK(enc_bits_last, f ? b : 3'h0)
      end
      enc_ready = 1'b1;
      @(negedge clk_sys);
      enc_ready = 1'b0;
    end
    for (int k = 0; k < 20 && tx_eof !== 1'b1; k++) @(negedge clk_sys);
    `CHK(tx_eof, 1'b1)
    u_fst_host_model.reg_read(FST_OFS_TX_LENGTH_HIGH, d);
    `CHK(d, FST_TXLEN_RESET)
    u_fst_host_model.reg_read(FST_OFS_TX_LENGTH_LOW_PARTIAL, d);
    `CHK(d, FST_TXLEN_RESET)
  endtask : tx_run

  // ----------------------------------------------------------------
  // Verdict and watchdog
  // ----------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
    begin
      $display("STATUS OK");
    end
    else
    begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict

  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      err_count++;
      give_verdict();
    end
  end

  initial
  begin
    cyc = 0;
    err_count = 0;
    n_tests = 0;
    rstn = 1'b0;
    chip_en = 1'b1;
    tx_start = 1'b0;
    enc_ready = 1'b0;
    repeat (12) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (3) @(negedge clk_sys);
    check_reset();
    check_fill();
    check_overflow();
    tx_run(12'h002, 3'h2, 1'b1);
    tx_run(12'h001, 3'h7, 1'b0);
    tx_run(12'h011, 3'h5, 1'b1);
    tx_run(12'h000, 3'h0, 1'b0);
    give_verdict();
  end
endmodule : test_fst_top
